//--- hdl/fdm_regs.sv
// algorithm control register bank: gain readback, monitor configuration, unlock key, commit
`timescale 1ns/1ps
`include "fdm_defs.svh"

// Contract
// - Writing one to the commit bit copies measured motor parameters into the shadow registers; the bit is write-only.
// - The current-loop gain readback is read-only with integral gain in 31-16 and proportional gain in 15-0.
// - The speed-loop gain readback is read-only with integral gain in 31-16 and proportional gain in 15-0.
// - Monitor one shows the variable addressed by bits 11-0 of its configuration register.
// - Monitor two shows the variable addressed by bits 13-0 of its configuration register.
// - Monitor one scale field in bits 16-13 scales by code/8, code zero meaning enum handling.
// - Monitor one enum multiplier in bits 20-17 multiplies by two to its power, only while scale is zero.
// - Monitor one polarity bit 12 selects bipolar with 1.5 V offset (0) or unipolar (1).
// - Monitor two scale field in bits 18-15 scales by code/8, code zero meaning enum handling.
// - Monitor two enum multiplier in bits 22-19 multiplies by two to its power, only while scale is zero.
// - Monitor two polarity bit 14 selects bipolar with 1.5 V offset (0) or unipolar (1).
// - With scale zero the variable is an enumerated quantity with largest value 31.
// - In lock mode 1 or 2 the nonvolatile memory unlocks only when the written key matches the stored one.
module fdm_regs #(
    parameter int VW = 16,
    parameter int PW = 32
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // register port, one access per strobe
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [11:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    output logic [31:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // gains in use by the control loops
    input wire fdm_pkg::fdm_gain_pair_t current_gain_i,
    input wire fdm_pkg::fdm_gain_pair_t speed_gain_i,
    // variable lookup, one port per monitor
    output logic [11:0] mon1_variable_address_o,
    output logic [13:0] mon2_variable_address_o,
    input wire logic signed [VW-1:0] mon1_var_i,
    input wire logic signed [VW-1:0] mon2_var_i,
    output logic [VW-1:0] monitor_out_one_o,
    output logic [VW-1:0] monitor_out_two_o,
    // measured parameter commit
    input wire logic [PW-1:0] measured_params_i,
    output logic [PW-1:0] shadow_params_o,
    output logic commit_measured_params_o,
    // nonvolatile lock
    input wire logic [1:0] lock_mode_i,
    input wire logic [14:0] lock_key_i,
    output logic nv_unlocked_o
);

    logic [31:0] mon1_cfg;
    logic [31:0] mon2_cfg;
    logic [14:0] user_key;
    fdm_pkg::fdm_mon_cfg_t mon1_fields;
    fdm_pkg::fdm_mon_cfg_t mon2_fields;
    logic [VW-1:0] mon1_code;
    logic [VW-1:0] mon2_code;
    logic sel_cur;
    logic sel_spd;
    logic sel_mon1;
    logic sel_mon2;
    logic sel_key;
    logic commit_hit;
    logic lock_active;
    logic next_unlocked;
    logic [31:0] next_rdata;

    assign sel_cur = (reg_addr_i == `FDM_OFF_CUR_PI);
    assign sel_spd = (reg_addr_i == `FDM_OFF_SPD_PI);
    assign sel_mon1 = (reg_addr_i == `FDM_OFF_MON1);
    assign sel_mon2 = (reg_addr_i == `FDM_OFF_MON2);
    assign sel_key = (reg_addr_i == `FDM_OFF_KEY);
    // the commit bit sits in the debug register just below this bank
    assign commit_hit = reg_wr_i && (reg_addr_i == `FDM_OFF_COMMIT) && reg_wdata_i[0];

    assign mon1_fields.enum_mult = mon1_cfg[`FDM_M1_ENUM_LSB +: 4];
    assign mon1_fields.scale = mon1_cfg[`FDM_M1_SCALE_LSB +: 4];
    assign mon1_fields.polarity = mon1_cfg[`FDM_M1_POL_BIT];
    assign mon2_fields.enum_mult = mon2_cfg[`FDM_M2_ENUM_LSB +: 4];
    assign mon2_fields.scale = mon2_cfg[`FDM_M2_SCALE_LSB +: 4];
    assign mon2_fields.polarity = mon2_cfg[`FDM_M2_POL_BIT];

    // readback is 10-bit values zero-extended into 16-bit halves; writes there are ignored
    assign next_rdata = sel_cur ? {6'h00, current_gain_i.integral, 6'h00, current_gain_i.proportional}
                      : sel_spd ? {6'h00, speed_gain_i.integral, 6'h00, speed_gain_i.proportional}
                      : sel_mon1 ? mon1_cfg
                      : sel_mon2 ? mon2_cfg
                      : sel_key ? {17'h00000, user_key}
                      : 32'h00000000;

    assign lock_active = (lock_mode_i == `FDM_LOCK_MODE1) || (lock_mode_i == `FDM_LOCK_MODE2);
    // key compared live, so a mode or key change relocks without a new write
    assign next_unlocked = !lock_active || (user_key == lock_key_i);

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            mon1_cfg <= `FDM_RST_MON1;
            mon2_cfg <= `FDM_RST_MON2;
            user_key <= `FDM_RST_KEY;
        end
        else if (reg_wr_i)
        begin
            if (sel_mon1)
                mon1_cfg <= reg_wdata_i & `FDM_M1_WMASK;
            if (sel_mon2)
                mon2_cfg <= reg_wdata_i & `FDM_M2_WMASK;
            if (sel_key)
                user_key <= reg_wdata_i[14:0];
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            reg_rdata_o <= 32'h00000000;
            reg_rvalid_o <= 1'b0;
            shadow_params_o <= '0;
            commit_measured_params_o <= 1'b0;
            nv_unlocked_o <= 1'b0;
            mon1_variable_address_o <= 12'h000;
            mon2_variable_address_o <= 14'h0000;
            monitor_out_one_o <= '0;
            monitor_out_two_o <= '0;
        end
        else
        begin
            reg_rdata_o <= reg_rd_i ? next_rdata : 32'h00000000;
            reg_rvalid_o <= reg_rd_i;
            if (commit_hit)
                shadow_params_o <= measured_params_i;
            commit_measured_params_o <= commit_hit;
            nv_unlocked_o <= next_unlocked;
            mon1_variable_address_o <= mon1_cfg[11:0];
            mon2_variable_address_o <= mon2_cfg[13:0];
            monitor_out_one_o <= mon1_code;
            monitor_out_two_o <= mon2_code;
        end
    end

    fdm_monitor_scaler #(.VW(VW)) u_mon1 (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .cfg_i(mon1_fields),
        .var_i(mon1_var_i),
        .code_o(mon1_code)
    );

    fdm_monitor_scaler #(.VW(VW)) u_mon2 (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .cfg_i(mon2_fields),
        .var_i(mon2_var_i),
        .code_o(mon2_code)
    );

endmodule : fdm_regs

//--- hdl/fdm_defs.svh
// register offsets, field positions, reset values for the monitor control register bank
`ifndef FDM_DEFS_SVH
`define FDM_DEFS_SVH

`define FDM_OFF_CUR_PI 12'h0F0
`define FDM_OFF_SPD_PI 12'h0F2
`define FDM_OFF_MON1 12'h0F4
`define FDM_OFF_MON2 12'h0F6
`define FDM_OFF_KEY 12'h0F8
`define FDM_OFF_COMMIT 12'h0EE

`define FDM_RST_MON1 32'h00110000
`define FDM_RST_MON2 32'h00040000
`define FDM_RST_KEY 15'h0000

`define FDM_M1_ADDR_LSB 0
`define FDM_M1_POL_BIT 12
`define FDM_M1_SCALE_LSB 13
`define FDM_M1_ENUM_LSB 17
`define FDM_M1_WMASK 32'h001FFFFF

`define FDM_M2_ADDR_LSB 0
`define FDM_M2_POL_BIT 14
`define FDM_M2_SCALE_LSB 15
`define FDM_M2_ENUM_LSB 19
`define FDM_M2_WMASK 32'h007FFFFF

`define FDM_KEY_WMASK 32'h00007FFF
`define FDM_ENUM_MAX 16'h001F
`define FDM_BIPOLAR_OFFSET 16'h8000
`define FDM_LOCK_NONE 2'h0
`define FDM_LOCK_MODE1 2'h1
`define FDM_LOCK_MODE2 2'h2

`endif

//--- hdl/fdm_pkg.sv
// types for the monitor control register bank
package fdm_pkg;

    typedef struct packed {
        logic [3:0] enum_mult;
        logic [3:0] scale;
        logic polarity;
    } fdm_mon_cfg_t;

    typedef struct packed {
        logic [9:0] integral;
        logic [9:0] proportional;
    } fdm_gain_pair_t;

endpackage : fdm_pkg

//--- hdl/fdm_monitor_scaler.sv
// one monitor channel: scale, enum handling and polarity of the selected variable
`timescale 1ns/1ps
`include "fdm_defs.svh"

module fdm_monitor_scaler #(
    parameter int VW = 16
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // configuration and sample
    input wire fdm_pkg::fdm_mon_cfg_t cfg_i,
    input wire logic signed [VW-1:0] var_i,
    // output code, 0 .. full scale
    output logic [VW-1:0] code_o
);

    logic signed [VW+4:0] scaled;
    logic signed [VW+4:0] enum_clip;
    logic signed [VW+4:0] enum_shift;
    logic signed [VW+4:0] chosen;
    logic signed [VW+4:0] max_pos;
    logic signed [VW+4:0] max_neg;
    logic signed [VW+4:0] clipped;
    logic [VW-1:0] next_code;

    // scale by code/8, scale code zero goes to enum handling
    // sample widened first so the product is formed at full width, not at the sample's width
    assign scaled = ($signed({1'b0, cfg_i.scale}) * (VW+5)'(var_i)) >>> 3;
    // enum quantity saturates at 31 before the power-of-two multiplier
    assign enum_clip = (var_i > VW'(signed'(`FDM_ENUM_MAX))) ? (VW+5)'(`FDM_ENUM_MAX)
                     : (var_i < 0) ? (VW+5)'(0) : (VW+5)'(var_i);
    assign enum_shift = enum_clip <<< cfg_i.enum_mult;
    assign chosen = (cfg_i.scale == 4'h0) ? enum_shift : scaled;
    // unipolar has no offset and full positive range; bipolar is centred at mid scale
    assign max_pos = cfg_i.polarity ? (VW+5)'({VW{1'b1}}) : (VW+5)'({(VW-1){1'b1}});
    assign max_neg = cfg_i.polarity ? (VW+5)'(0) : -(VW+5)'(`FDM_BIPOLAR_OFFSET);
    assign clipped = (chosen > max_pos) ? max_pos : (chosen < max_neg) ? max_neg : chosen;
    assign next_code = cfg_i.polarity ? clipped[VW-1:0]
                     : VW'(clipped[VW-1:0] + VW'(`FDM_BIPOLAR_OFFSET));

    // refreshed every cycle so a config change shows at the next update
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            code_o <= '0;
        else
            code_o <= next_code;
    end

endmodule : fdm_monitor_scaler

//--- testbench/fdm_regs_sva.sv
// port assertions for the monitor control register bank
`timescale 1ns/1ps
module fdm_regs_chk #(
    parameter int PW = 32
) (
    input wire logic core_clk_i, input wire logic rst_i, input wire logic reg_wr_i, input wire logic reg_rd_i,
    input wire logic [11:0] reg_addr_i, input wire logic [31:0] reg_wdata_i, input wire logic [31:0] reg_rdata_o,
    input wire logic reg_rvalid_o, input wire fdm_pkg::fdm_gain_pair_t current_gain_i,
    input wire logic [11:0] mon1_variable_address_o, input wire logic [13:0] mon2_variable_address_o,
    input wire logic [PW-1:0] measured_params_i, input wire logic [PW-1:0] shadow_params_o,
    input wire logic commit_measured_params_o, input wire logic [1:0] lock_mode_i, input wire logic [14:0] lock_key_i,
    input wire logic nv_unlocked_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    wire [31:0] cur_word = {6'h00, current_gain_i.integral, 6'h00, current_gain_i.proportional};
    wire commit_wr = reg_wr_i && reg_wdata_i[0] && reg_addr_i == 12'h0EE;
    AST_RD_LAT: assert property (reg_rd_i |=> reg_rvalid_o)
        else $error("read answer missing");
    AST_CUR_RB: assert property (reg_rd_i && reg_addr_i == 12'h0F0 |=> reg_rdata_o == $past(cur_word))
        else $error("current gain readback wrong");
    AST_COMMIT: assert property (commit_wr |=> commit_measured_params_o && shadow_params_o == $past(measured_params_i))
        else $error("commit did not copy");
    AST_COMMIT_RD: assert property (reg_rd_i && reg_addr_i == 12'h0EE |=> reg_rdata_o == 32'h0)
        else $error("commit bit readable");
    AST_ADDR1: assert property (reg_wr_i && reg_addr_i == 12'h0F4 |=> ##1 mon1_variable_address_o == $past(reg_wdata_i[11:0], 2))
        else $error("monitor one address wrong");
    AST_ADDR2: assert property (reg_wr_i && reg_addr_i == 12'h0F6 |=> ##1 mon2_variable_address_o == $past(reg_wdata_i[13:0], 2))
        else $error("monitor two address wrong");
    AST_OPEN: assert property (!(^lock_mode_i) |=> nv_unlocked_o)
        else $error("unlocked mode stays locked");
    AST_KEY: assert property (reg_wr_i && reg_addr_i == 12'h0F8 ##1 ^lock_mode_i |=>
        nv_unlocked_o == ($past(reg_wdata_i[14:0], 2) == $past(lock_key_i))) else $error("key match wrong");
    COV_COMMIT: cover property (commit_measured_params_o);
    COV_UNLOCK: cover property (^lock_mode_i ##1 nv_unlocked_o);
    COV_READ: cover property (reg_rvalid_o);
endmodule : fdm_regs_chk
bind fdm_regs fdm_regs_chk #(.PW(PW)) u_chk (.core_clk_i, .rst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
    .reg_rdata_o, .reg_rvalid_o, .current_gain_i, .mon1_variable_address_o, .mon2_variable_address_o,
    .measured_params_i, .shadow_params_o, .commit_measured_params_o, .lock_mode_i, .lock_key_i, .nv_unlocked_o);

//--- testbench/fdm_var_src.sv
// variable store: answers each monitor address with that address sign-extended
`timescale 1ns/1ps
module fdm_var_src (
    // lookups and answers
    input wire logic [11:0] addr1_i,
    input wire logic [13:0] addr2_i,
    output logic signed [15:0] var1_o,
    output logic signed [15:0] var2_o
);
    assign var1_o = {{4{addr1_i[11]}}, addr1_i};
    assign var2_o = {{2{addr2_i[13]}}, addr2_i};
endmodule : fdm_var_src

//--- testbench/test_foc_debug_monitor_control_regs.sv
// self-checking bench for the monitor control register bank
`timescale 1ns/1ps
module test_foc_debug_monitor_control_regs;
    logic core_clk_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, reg_rvalid_o, cm, nv;
    logic [11:0] reg_addr_i = 12'h000, a1;
    logic [13:0] a2;
    logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, mp = 32'h0, sh, w1, w2, q[$];
    logic [1:0] lm = 2'h0;
    logic [14:0] lk = 15'h0;
    logic [15:0] o1, o2, s = 16'h0037;
    logic signed [15:0] v1, v2;
    fdm_pkg::fdm_gain_pair_t cg = '0, sg = '0;
    logic [44:0] tbl [11] = '{{1'b0, 12'h0F4, 32'h00110000}, {1'b0, 12'h0F6, 32'h00040000}, {1'b0, 12'h0F8, 32'h0},
        {1'b0, 12'h100, 32'h0}, {1'b1, 12'h0F0, 32'hFFFFFFFF}, {1'b1, 12'h0F4, 32'hFFFFFFFF}, {1'b1, 12'h0F6, 32'hFFFFFFFF},
        {1'b1, 12'h0F8, 32'hFFFFFFFF}, {1'b0, 12'h0F4, 32'h001FFFFF}, {1'b0, 12'h0F6, 32'h007FFFFF}, {1'b0, 12'h0F8, 32'h00007FFF}};
    int err_count = 0, samples_checked = 0, cyc = 0;
    fdm_regs dut (.core_clk_i, .rst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o,
        .current_gain_i(cg), .speed_gain_i(sg), .mon1_variable_address_o(a1), .mon2_variable_address_o(a2),
        .mon1_var_i(v1), .mon2_var_i(v2), .monitor_out_one_o(o1), .monitor_out_two_o(o2), .measured_params_i(mp),
        .shadow_params_o(sh), .commit_measured_params_o(cm), .lock_mode_i(lm), .lock_key_i(lk), .nv_unlocked_o(nv));
    fdm_var_src src (.addr1_i(a1), .addr2_i(a2), .var1_o(v1), .var2_o(v2));
    initial forever #12.5 core_clk_i = ~core_clk_i;
    function automatic logic [15:0] nx(logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : nx
    // scale, enum clamp to 31 and shift, then clip to the code range of the chosen polarity
    function automatic logic [31:0] ex(int v, int sc, int e, logic u);
        int r;
        r = (sc != 0) ? (v * sc) >>> 3 : ((v < 0) ? 0 : (v > 31) ? 31 : v) << e;
        if (u)
            r = (r < 0) ? 0 : (r > 65535) ? 65535 : r;
        else
            r = ((r < -32768) ? -32768 : (r > 32767) ? 32767 : r) + 32768;
        return {16'h0000, r[15:0]};
    endfunction : ex
    task automatic chk(logic [31:0] g, logic [31:0] e);
        samples_checked++;
        if (g !== e)
        begin
            err_count++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // one strobe per access; a read notes its expected word for the watcher
    task automatic acc(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge core_clk_i);
        #2;
        reg_wr_i = w;
        reg_rd_i = !w;
        reg_addr_i = a;
        reg_wdata_i = d;
        if (!w)
            q.push_back(d);
        @(posedge core_clk_i);
        #2;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
    endtask : acc
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize
    always @(negedge core_clk_i)
    begin
        cyc++;
        if (reg_rvalid_o === 1'b1)
            chk(reg_rdata_o, q.pop_front());
        if (cyc > 2000)
        begin
            err_count++;
            $display("ERROR %0t timeout", $time);
            summarize();
        end
    end
    initial
    begin
        repeat (4) @(posedge core_clk_i);
        #2;
        rst_i = 1'b0;
        foreach (tbl[i]) acc(tbl[i][44], tbl[i][43:32], tbl[i][31:0]);
        s = nx(s);
        cg = {s[9:0], s[15:6]};
        sg = {s[5:0], s[13:0]};
        acc(1'b0, 12'h0F0, {6'h00, cg.integral, 6'h00, cg.proportional});
        acc(1'b0, 12'h0F2, {6'h00, sg.integral, 6'h00, sg.proportional});
        $display("test registers done");
        for (int i = 0; i < 24; i++)
        begin
            s = nx(s);
            w1 = {11'h000, s[7:4], (i % 4 == 0) ? 4'h0 : s[3:0], s[8], s[11:0]};
            s = nx(s);
            w2 = {9'h000, s[7:4], (i % 4 == 1) ? 4'h0 : s[3:0], s[8], s[13:0]};
            acc(1'b1, 12'h0F4, w1);
            acc(1'b1, 12'h0F6, w2);
            repeat (6) @(posedge core_clk_i);
            #2;
            chk(32'(o1), ex($signed(w1[11:0]), w1[16:13], w1[20:17], w1[12]));
            chk(32'(o2), ex($signed(w2[13:0]), w2[18:15], w2[22:19], w2[14]));
        end
        // recommended scale codes, unipolar, positive variable: the host recovers the variable from the code
        for (int k = 0; k < 3; k++)
        begin
            s = nx(s);
            w1 = {15'h0000, (k == 0) ? 4'h2 : (k == 1) ? 4'h8 : 4'h7, 1'b1, 1'b0, s[10:0]};
            acc(1'b1, 12'h0F4, w1);
            repeat (6) @(posedge core_clk_i);
            #2;
            chk(32'(o1), ex(int'(w1[11:0]), int'(w1[16:13]), 0, 1'b1));
            chk(32'((int'(w1[11:0]) - int'(o1) * 8 / int'(w1[16:13])) < 4), 32'h1);
        end
        $display("test monitors done");
        mp = {s, ~s};
        acc(1'b1, 12'h0EE, 32'h1);
        chk(32'(cm), 32'h1);
        chk(sh, mp);
        w1 = mp;
        mp = ~mp;
        acc(1'b1, 12'h0EE, 32'h2);
        chk(sh, w1);
        chk(32'(cm), 32'h0);
        acc(1'b0, 12'h0EE, 32'h0);
        for (int m = 0; m < 8; m++)
        begin
            s = nx(s);
            lm = m[1:0];
            lk = s[14:0];
            acc(1'b1, 12'h0F8, {17'h00000, m[2] ? s[14:0] : ~s[14:0]});
            @(posedge core_clk_i);
            #2;
            chk(32'(nv), {31'h0, (^lm) ? m[2] : 1'b1});
        end
        chk(32'(q.size()), 32'h0);
        $display("test commit and unlock done");
        summarize();
    end
endmodule : test_foc_debug_monitor_control_regs
